// *** verilog/bbc_core.sv ***
// Operation
// RULE_01 - A conditional branch jumps only when its condition holds, else falls through.
// RULE_02 - Carry/zero short branches use a 5-bit signed displacement, -15 to +16.
// RULE_03 - Bit test branches use an 8-bit signed displacement, -126 to +129.
// RULE_04 - Bit test branch copies the tested bit to carry, keeps zero.
// RULE_05 - Branch-if-clear jumps on 0, branch-if-set on 1; 3 bytes, 5 cycles.
// RULE_06 - Any bit of any data byte: 3-bit position, address byte.
// RULE_07 - Set forces one, clear forces zero; 2 bytes, 4 cycles, no flags.
// RULE_08 - Control instructions are 1 byte, 2 cycles; only interrupt exit changes flags.
// RULE_09 - With watchdog selected, stop is replaced by wait.
// RULE_10 - Long jump and call take 12-bit address; 2 bytes, 4 cycles, no flags.
// RULE_11 - Low nibble 0000 nonzero branch, 0001 call, 0010 no-carry branch.
// RULE_12 - Opcode bit 4 picks the indirect register; such instructions are 1 byte.
// RULE_13 - Call pushes the next address; return restores the program counter.
`timescale 1ns/1ps
`include "bbc_params.svh"

module bbc_core
(
	input  wire logic        mclk,         // Core clock, 40 MHz.
	input  wire logic        rst_n,        // Asynchronous reset, active low.
	output logic [11:0]      pm_addr,      // Program memory address.
	input  wire logic [7:0]  pm_data,      // Program memory byte at pm_addr.
	output logic [7:0]       ds_addr,      // Data space address.
	input  wire logic [7:0]  ds_rdata,     // Data space byte at ds_addr.
	output logic [7:0]       ds_wdata,     // Data space write byte.
	output logic             ds_we,        // Data space write strobe.
	output logic [11:0]      pc,           // Program counter.
	output logic             flag_z,       // Zero flag.
	output logic             flag_c,       // Carry flag.
	input  wire logic        irq_flag_z,   // Zero flag saved at interrupt entry.
	input  wire logic        irq_flag_c,   // Carry flag saved at interrupt entry.
	output logic             int_exit,     // Pulse when interrupt exit completes.
	input  wire logic        wdog_sel,     // Watchdog function selected.
	input  wire logic        wake,         // Leave wait or stop mode.
	output logic             wait_mode,    // Core in wait mode.
	output logic             stop_mode,    // Core in stop mode.
	output logic             ext_req,      // Opcode belongs to another group.
	output logic [7:0]       ext_opcode,   // Opcode handed to that group.
	output logic             ext_ind_sel,  // Indirect register select of that opcode.
	input  wire logic        ext_done,     // Other group finished.
	input  wire logic [1:0]  ext_len,      // Byte length of that instruction.
	input  wire logic        ext_flag_we,  // Other group writes the flags.
	input  wire logic        ext_z,        // Zero flag from other group.
	input  wire logic        ext_c,        // Carry flag from other group.
	output logic             instr_done    // Pulse on last cycle of each instruction.
);

	bbc_dec_if dec ();
	bbc_stk_if stk ();

	bbc_decode u_dec
	(
		.d     (dec)
	);

	bbc_stack u_stk
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.s     (stk)
	);

	//----------------------------------------------------------------
	// State
	//----------------------------------------------------------------
	bbc_pkg::bbc_state_t st;
	bbc_pkg::bbc_state_t next_st;
	logic [2:0]          cnt;
	logic [2:0]          next_cnt;
	logic [11:0]         next_pc;
	logic [7:0]          op;
	logic [7:0]          next_op;
	logic [7:0]          b2;
	logic [7:0]          next_b2;
	logic [7:0]          b3;
	logic [7:0]          next_b3;
	logic [7:0]          dbyte;
	logic [7:0]          next_dbyte;
	logic                next_z;
	logic                next_c;

	logic                cond;
	logic                bitval;
	logic [11:0]         sbr_target;
	logic [11:0]         btb_target;
	logic [7:0]          mask;
	logic                last;

	function automatic logic [11:0] sext5(input logic [4:0] v);
		sext5 = {{7{v[4]}}, v};
	endfunction

	function automatic logic [11:0] sext8(input logic [7:0] v);
		sext8 = {{4{v[7]}}, v};
	endfunction

	function automatic logic [2:0] last_cycle(input bbc_pkg::bbc_cls_t k);
		case (k)
			bbc_pkg::BBC_BTB:  last_cycle = `BBC_LAST_BTB;
			bbc_pkg::BBC_BIT:  last_cycle = `BBC_LAST_BIT;
			bbc_pkg::BBC_LJP,
			bbc_pkg::BBC_CALL: last_cycle = `BBC_LAST_LONG;
			bbc_pkg::BBC_SBR:  last_cycle = `BBC_LAST_SBR;
			default:           last_cycle = `BBC_LAST_CTL;
		endcase
	endfunction

	assign dec.opcode  = (cnt == 3'h0) ? pm_data : op;
	assign ext_opcode  = op;
	assign ext_ind_sel = dec.ind_sel;    // RULE_12
	assign wait_mode   = (st == bbc_pkg::BBC_WAITING);
	assign stop_mode   = (st == bbc_pkg::BBC_STOPPED);
	assign mask        = 8'h01 << dec.bit_sel;    // RULE_06
	assign bitval      = dbyte[dec.bit_sel];
	assign sbr_target  = pc + `BBC_SBR_BASE + sext5(dec.disp5);    // RULE_02
	assign btb_target  = pc + `BBC_BTB_BASE + sext8(b3);    // RULE_03
	assign last        = (cnt != 3'h0) && (cnt == last_cycle(dec.cls));

	always_comb
	begin
		case (op[2:0])
			`BBC_SC_ZERO:    cond = flag_z;
			`BBC_SC_NOCARRY: cond = !flag_c;
			`BBC_SC_CARRY:   cond = flag_c;
			default:         cond = !flag_z;
		endcase
	end

	//----------------------------------------------------------------
	// Sequencer
	//----------------------------------------------------------------
	always_comb
	begin
		next_st    = st;
		next_cnt   = cnt;
		next_pc    = pc;
		next_op    = op;
		next_b2    = b2;
		next_b3    = b3;
		next_dbyte = dbyte;
		next_z     = flag_z;
		next_c     = flag_c;
		pm_addr    = pc;
		ds_addr    = b2;
		ds_wdata   = dbyte;
		ds_we      = 1'b0;
		stk.push   = 1'b0;
		stk.pop    = 1'b0;
		stk.wdata  = pc + `BBC_LEN_TWO;
		int_exit   = 1'b0;
		ext_req    = 1'b0;
		instr_done = 1'b0;
		case (st)
			bbc_pkg::BBC_RUN:
			begin
				case (cnt)
					3'h0:
					begin
						next_op  = pm_data;
						next_cnt = 3'h1;
					end
					3'h1:
					begin
						pm_addr = pc + `BBC_LEN_ONE;
						next_b2 = pm_data;
					end
					3'h2:
					begin
						if (dec.cls == bbc_pkg::BBC_BTB)
						begin
							pm_addr = pc + `BBC_LEN_TWO;
							next_b3 = pm_data;
						end
						else
							next_dbyte = ds_rdata;
					end
					3'h3:
					begin
						if (dec.cls == bbc_pkg::BBC_BTB)
							next_dbyte = ds_rdata;
					end
					default:
					begin
					end
				endcase
				if (cnt != 3'h0 && dec.cls == bbc_pkg::BBC_EXT)
				begin
					ext_req = 1'b1;
					if (ext_done)
					begin
						instr_done = 1'b1;
						next_cnt   = 3'h0;
						next_pc    = pc + {10'h000, ext_len};
						if (ext_flag_we)
						begin
							next_z = ext_z;
							next_c = ext_c;
						end
					end
				end
				else if (last)
				begin
					instr_done = 1'b1;
					next_cnt   = 3'h0;
					case (dec.cls)
						bbc_pkg::BBC_SBR:
							next_pc = cond ? sbr_target : pc + `BBC_LEN_ONE;    // RULE_01
						bbc_pkg::BBC_BTB:
						begin
							next_c = bitval;    // RULE_04
							if (dec.set_form == bitval)    // RULE_05
								next_pc = btb_target;
							else
								next_pc = pc + `BBC_LEN_THREE;
						end
						bbc_pkg::BBC_BIT:
						begin
							ds_we    = 1'b1;
							ds_wdata = dec.set_form ? (dbyte | mask) : (dbyte & ~mask);    // RULE_07
							next_pc  = pc + `BBC_LEN_TWO;
						end
						bbc_pkg::BBC_LJP:
							next_pc = {dec.addr_hi, b2};    // RULE_10
						bbc_pkg::BBC_CALL:
						begin
							stk.push = 1'b1;    // RULE_13
							next_pc  = {dec.addr_hi, b2};
						end
						bbc_pkg::BBC_RET,
						bbc_pkg::BBC_INTERRUPT_EXIT:
						begin
							stk.pop = 1'b1;
							next_pc = stk.rdata;    // RULE_13
							if (dec.cls == bbc_pkg::BBC_INTERRUPT_EXIT)
							begin
								next_z   = irq_flag_z;    // RULE_08
								next_c   = irq_flag_c;
								int_exit = 1'b1;
							end
						end
						bbc_pkg::BBC_STOP:
						begin
							next_pc = pc + `BBC_LEN_ONE;
							next_st = wdog_sel ? bbc_pkg::BBC_WAITING : bbc_pkg::BBC_STOPPED;    // RULE_09
						end
						bbc_pkg::BBC_WAIT:
						begin
							next_pc = pc + `BBC_LEN_ONE;
							next_st = bbc_pkg::BBC_WAITING;
						end
						default:
							next_pc = pc + `BBC_LEN_ONE;
					endcase
				end
				else if (cnt != 3'h0)
					next_cnt = cnt + 3'h1;
			end
			bbc_pkg::BBC_WAITING,
			bbc_pkg::BBC_STOPPED:
			begin
				if (wake)
					next_st = bbc_pkg::BBC_RUN;
			end
			default:
				next_st = bbc_pkg::BBC_RUN;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st     <= bbc_pkg::BBC_RUN;
			cnt    <= 3'h0;
			pc     <= `BBC_PC_RESET;
			op     <= 8'h00;
			b2     <= 8'h00;
			b3     <= 8'h00;
			dbyte  <= 8'h00;
			flag_z <= 1'b0;
			flag_c <= 1'b0;
		end
		else
		begin
			st     <= next_st;
			cnt    <= next_cnt;
			pc     <= next_pc;
			op     <= next_op;
			b2     <= next_b2;
			b3     <= next_b3;
			dbyte  <= next_dbyte;
			flag_z <= next_z;
			flag_c <= next_c;
		end
	end

	//----------------------------------------------------------------
	// Assertions
	//----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_low_nibble;
		dec.opcode[3:0] == 4'h2 |-> dec.cls == bbc_pkg::BBC_SBR;
	endproperty
	a_low_nibble: assert property (p_low_nibble) else $error("Low nibble 2 not a short branch."); // RULE_11

	property p_sbr;
		instr_done && dec.cls == bbc_pkg::BBC_SBR
			|=> pc == ($past(cond) ? $past(sbr_target) : $past(pc) + 12'h001);
	endproperty
	a_sbr: assert property (p_sbr) else $error("Short branch target wrong."); // RULE_01

	property p_sbr_len;
		instr_done && dec.cls == bbc_pkg::BBC_SBR |-> cnt == 3'h1 && $past(cnt) == 3'h0;
	endproperty
	a_sbr_len: assert property (p_sbr_len) else $error("Short branch not two cycles."); // RULE_02

	property p_btb;
		instr_done && dec.cls == bbc_pkg::BBC_BTB
			|=> flag_c == $past(bitval) && flag_z == $past(flag_z)
			&& pc == (($past(bitval) == $past(dec.set_form)) ? $past(btb_target)
			: $past(pc) + 12'h003);
	endproperty
	a_btb: assert property (p_btb) else $error("Bit test branch result wrong."); // RULE_04

	property p_btb_len;
		instr_done && dec.cls == bbc_pkg::BBC_BTB |-> cnt == 3'h4;
	endproperty
	a_btb_len: assert property (p_btb_len) else $error("Bit test branch not five cycles."); // RULE_05

	property p_bit_write;
		ds_we |-> cnt == 3'h3 && ds_addr == b2
			&& ds_wdata[dec.bit_sel] == dec.set_form
			&& (ds_wdata & ~mask) == (dbyte & ~mask);
	endproperty
	a_bit_write: assert property (p_bit_write) else $error("Bit write wrong."); // RULE_07

	property p_ctl;
		instr_done && (dec.cls == bbc_pkg::BBC_NOP || dec.cls == bbc_pkg::BBC_WAIT
			|| dec.cls == bbc_pkg::BBC_STOP || dec.cls == bbc_pkg::BBC_RET)
			|-> cnt == 3'h1 ##1 flag_z == $past(flag_z) && flag_c == $past(flag_c);
	endproperty
	a_ctl: assert property (p_ctl) else $error("Control instruction timing or flags wrong."); // RULE_08

	property p_stop_wd;
		instr_done && dec.cls == bbc_pkg::BBC_STOP && wdog_sel |=> wait_mode && !stop_mode;
	endproperty
	a_stop_wd: assert property (p_stop_wd) else $error("Stop not replaced by wait."); // RULE_09

	property p_long;
		instr_done && (dec.cls == bbc_pkg::BBC_LJP || dec.cls == bbc_pkg::BBC_CALL)
			|-> cnt == 3'h3 ##1 pc == {$past(op[7:4]), $past(b2)} && flag_c == $past(flag_c);
	endproperty
	a_long: assert property (p_long) else $error("Long jump or call wrong."); // RULE_10

	property p_call;
		instr_done && dec.cls == bbc_pkg::BBC_CALL |-> stk.push && stk.wdata == pc + 12'h002;
	endproperty
	a_call: assert property (p_call) else $error("Call did not save next address."); // RULE_13

	c_btb_taken: cover property (instr_done && dec.cls == bbc_pkg::BBC_BTB
		&& bitval == dec.set_form);
	c_call_ret: cover property (instr_done && dec.cls == bbc_pkg::BBC_CALL
		##[1:40] instr_done && dec.cls == bbc_pkg::BBC_RET);
	c_stop_wd: cover property (instr_done && dec.cls == bbc_pkg::BBC_STOP && wdog_sel);
	c_bit_set: cover property (ds_we && dec.set_form);

endmodule

// *** verilog/bbc_params.svh ***
`ifndef BBC_PARAMS_SVH
`define BBC_PARAMS_SVH

// Whole-opcode codes of the control instructions.
`define BBC_OP_NOP       8'h04
`define BBC_OP_RET       8'hCD
`define BBC_OP_INTERRUPT_EXIT      8'h4D
`define BBC_OP_STOP      8'h6D
`define BBC_OP_WAIT      8'hED

// Low-nibble and low-three-bit opcode fields.
`define BBC_LN_CALL      4'h1
`define BBC_LN_JUMP      4'h9
`define BBC_LN_BTB       4'h3
`define BBC_LN_BIT       4'hB
`define BBC_LN_CTL       4'hD
`define BBC_SC_NONZERO   3'h0
`define BBC_SC_ZERO      3'h4
`define BBC_SC_NOCARRY   3'h2
`define BBC_SC_CARRY     3'h6

// Field positions inside the opcode.
`define BBC_POS_FORM     4
`define BBC_POS_IND      4
`define BBC_POS_DISP     3

// Last cycle index of each instruction (cycle count minus one).
`define BBC_LAST_SBR     3'h1
`define BBC_LAST_BTB     3'h4
`define BBC_LAST_BIT     3'h3
`define BBC_LAST_LONG    3'h3
`define BBC_LAST_CTL     3'h1

// Program counter offsets: displacement bases and instruction lengths.
`define BBC_SBR_BASE     12'h001
`define BBC_BTB_BASE     12'h002
`define BBC_LEN_ONE      12'h001
`define BBC_LEN_TWO      12'h002
`define BBC_LEN_THREE    12'h003

// Reset values and hardware stack size.
`define BBC_PC_RESET     12'h000
`define BBC_STK_DEPTH    6
`define BBC_STK_PTR_W    3

`endif

// *** verilog/bbc_pkg.sv ***
package bbc_pkg;

	typedef enum logic [3:0]
	{
		BBC_SBR,
		BBC_BTB,
		BBC_BIT,
		BBC_LJP,
		BBC_CALL,
		BBC_NOP,
		BBC_RET,
		BBC_INTERRUPT_EXIT,
		BBC_STOP,
		BBC_WAIT,
		BBC_EXT
	} bbc_cls_t;

	typedef enum logic [1:0]
	{
		BBC_RUN,
		BBC_WAITING,
		BBC_STOPPED
	} bbc_state_t;

endpackage

// *** verilog/bbc_if.sv ***
`timescale 1ns/1ps

// Opcode in, decoded fields out.
interface bbc_dec_if;
	logic [7:0]          opcode;
	bbc_pkg::bbc_cls_t   cls;
	logic [2:0]          bit_sel;
	logic                set_form;
	logic [4:0]          disp5;
	logic [3:0]          addr_hi;
	logic                ind_sel;
	modport core (output opcode, input cls, bit_sel, set_form, disp5, addr_hi, ind_sel);
	modport dec  (input opcode, output cls, bit_sel, set_form, disp5, addr_hi, ind_sel);
endinterface

// Return address stack.
interface bbc_stk_if;
	logic        push;
	logic        pop;
	logic [11:0] wdata;
	logic [11:0] rdata;
	logic        empty;
	modport core  (output push, pop, wdata, input rdata, empty);
	modport stack (input push, pop, wdata, output rdata, empty);
endinterface

// *** verilog/bbc_decode.sv ***
`timescale 1ns/1ps
`include "bbc_params.svh"

module bbc_decode
(
	bbc_dec_if.dec d    // Opcode and decoded fields.
);

	always_comb
	begin
		d.cls      = bbc_pkg::BBC_EXT;
		d.bit_sel  = {d.opcode[5], d.opcode[6], d.opcode[7]};
		d.set_form = d.opcode[`BBC_POS_FORM];
		d.disp5    = d.opcode[7:`BBC_POS_DISP];
		d.addr_hi  = d.opcode[7:4];
		d.ind_sel  = d.opcode[`BBC_POS_IND];    // RULE_12
		if (d.opcode == `BBC_OP_NOP)
			d.cls = bbc_pkg::BBC_NOP;
		else if (d.opcode[2:0] == `BBC_SC_NONZERO || d.opcode[2:0] == `BBC_SC_ZERO ||
				d.opcode[2:0] == `BBC_SC_NOCARRY || d.opcode[2:0] == `BBC_SC_CARRY)
			d.cls = bbc_pkg::BBC_SBR;    // RULE_11
		else
		begin
			case (d.opcode[3:0])
				`BBC_LN_CALL: d.cls = bbc_pkg::BBC_CALL;    // RULE_11
				`BBC_LN_JUMP: d.cls = bbc_pkg::BBC_LJP;
				`BBC_LN_BTB:  d.cls = bbc_pkg::BBC_BTB;
				`BBC_LN_BIT:  d.cls = bbc_pkg::BBC_BIT;
				`BBC_LN_CTL:
				begin
					case (d.opcode)
						`BBC_OP_RET:  d.cls = bbc_pkg::BBC_RET;
						`BBC_OP_INTERRUPT_EXIT: d.cls = bbc_pkg::BBC_INTERRUPT_EXIT;
						`BBC_OP_STOP: d.cls = bbc_pkg::BBC_STOP;
						`BBC_OP_WAIT: d.cls = bbc_pkg::BBC_WAIT;
						default:      d.cls = bbc_pkg::BBC_EXT;
					endcase
				end
				default: d.cls = bbc_pkg::BBC_EXT;
			endcase
		end
	end

endmodule

// *** verilog/bbc_stack.sv ***
`timescale 1ns/1ps
`include "bbc_params.svh"

module bbc_stack
(
	input  wire logic mclk,     // Core clock.
	input  wire logic rst_n,    // Asynchronous reset, active low.
	bbc_stk_if.stack  s         // Push and pop port.
);

	logic [11:0]                 mem [`BBC_STK_DEPTH];
	logic [11:0]                 next_mem [`BBC_STK_DEPTH];
	logic [`BBC_STK_PTR_W-1:0]   top;
	logic [`BBC_STK_PTR_W-1:0]   next_top;
	logic [`BBC_STK_PTR_W:0]     fill;
	logic [`BBC_STK_PTR_W:0]     next_fill;

	function automatic logic [`BBC_STK_PTR_W-1:0] wrap_inc(input logic [`BBC_STK_PTR_W-1:0] v);
		wrap_inc = (v == `BBC_STK_PTR_W'(`BBC_STK_DEPTH - 1)) ? '0 : v + 1'b1;
	endfunction

	function automatic logic [`BBC_STK_PTR_W-1:0] wrap_dec(input logic [`BBC_STK_PTR_W-1:0] v);
		wrap_dec = (v == '0) ? `BBC_STK_PTR_W'(`BBC_STK_DEPTH - 1) : v - 1'b1;
	endfunction

	assign s.rdata = mem[top];
	assign s.empty = (fill == '0);

	// A push into a full stack overwrites the oldest entry.
	always_comb
	begin
		next_mem  = mem;
		next_top  = top;
		next_fill = fill;
		if (s.push)
		begin
			next_top           = wrap_inc(top);
			next_mem[next_top] = s.wdata;
			if (fill != (`BBC_STK_PTR_W+1)'(`BBC_STK_DEPTH))
				next_fill = fill + 1'b1;
		end
		else if (s.pop && fill != '0)
		begin
			next_top  = wrap_dec(top);
			next_fill = fill - 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < `BBC_STK_DEPTH; i++)
				mem[i] <= 12'h000;
			top  <= '0;
			fill <= '0;
		end
		else
		begin
			mem  <= next_mem;
			top  <= next_top;
			fill <= next_fill;
		end
	end

endmodule

// *** test/bbc_mem.sv ***
`timescale 1ns/1ps

// Program memory and data space; both answer in the same cycle, no wait states.
module bbc_mem
(
	input  wire logic        mclk,      // Core clock.
	input  wire logic [11:0] pm_addr,   // Program memory address.
	output logic [7:0]       pm_data,   // Program memory byte.
	input  wire logic [7:0]  ds_addr,   // Data space address.
	output logic [7:0]       ds_rdata,  // Data space read byte.
	input  wire logic [7:0]  ds_wdata,  // Data space write byte.
	input  wire logic        ds_we      // Data space write strobe.
);
	logic [7:0] pm [0:4095];
	logic [7:0] ds [0:255];

	assign pm_data  = pm[pm_addr];
	assign ds_rdata = ds[ds_addr];

	always @(posedge mclk)
	begin
		if (ds_we)
			ds[ds_addr] <= ds_wdata;
	end
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps

module testbench;
	logic        mclk;
	logic        rst_n;
	logic [11:0] pm_addr;
	logic [7:0]  pm_data;
	logic [7:0]  ds_addr;
	logic [7:0]  ds_rdata;
	logic [7:0]  ds_wdata;
	logic        ds_we;
	logic [11:0] pc;
	logic        flag_z;
	logic        flag_c;
	logic        irq_flag_z;
	logic        irq_flag_c;
	logic        int_exit;
	logic        wdog_sel;
	logic        wake;
	logic        wait_mode;
	logic        stop_mode;
	logic        instr_done;
	logic        ext_req;
	logic [7:0]  ext_opcode;
	logic        ext_ind_sel;
	logic        ext_done;
	logic [1:0]  ext_len;
	logic        ext_flag_we;
	logic        ext_z;
	logic        ext_c;
	logic        last_ie;
	int          n_mismatch;
	int          checked;
	int          cycles;

	bbc_core bbc_core_inst (.mclk(mclk), .rst_n(rst_n), .pm_addr(pm_addr), .pm_data(pm_data),
		.ds_addr(ds_addr), .ds_rdata(ds_rdata), .ds_wdata(ds_wdata), .ds_we(ds_we), .pc(pc),
		.flag_z(flag_z), .flag_c(flag_c), .irq_flag_z(irq_flag_z), .irq_flag_c(irq_flag_c),
		.int_exit(int_exit), .wdog_sel(wdog_sel), .wake(wake), .wait_mode(wait_mode),
		.stop_mode(stop_mode), .ext_req(ext_req), .ext_opcode(ext_opcode),
		.ext_ind_sel(ext_ind_sel), .ext_done(ext_done), .ext_len(ext_len),
		.ext_flag_we(ext_flag_we), .ext_z(ext_z), .ext_c(ext_c),
		.instr_done(instr_done));

	bbc_mem bbc_mem_inst (.mclk(mclk), .pm_addr(pm_addr), .pm_data(pm_data), .ds_addr(ds_addr),
		.ds_rdata(ds_rdata), .ds_wdata(ds_wdata), .ds_we(ds_we));

	always #12.5 mclk = ~mclk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Holds the core in reset while a new program is loaded.
	task automatic begin_test(input logic z, input logic c);
		@(negedge mclk);
		rst_n      = 1'b0;
		irq_flag_z = z;
		irq_flag_c = c;
		wdog_sel   = 1'b0;
		wake       = 1'b0;
		ext_done   = 1'b0;
		for (int i = 0; i < 4096; i++)
			bbc_mem_inst.pm[i] = 8'h00;
		for (int i = 0; i < 256; i++)
			bbc_mem_inst.ds[i] = 8'h5A;
	endtask

	task automatic put(input logic [11:0] a, input logic [23:0] b, input int n);
		for (int i = 0; i < n; i++)
			bbc_mem_inst.pm[a + i] = b[23 - 8 * i -: 8];
	endtask

	task automatic go();
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
	endtask

	// Runs one instruction, counting its cycles, then compares pc and flags.
	task automatic step(input string name, input int cyc, input logic [11:0] pc_exp,
		input logic z, input logic c);
		int   n;
		logic done;
		n    = 0;
		done = 1'b0;
		while (!done && n < 20)
		begin
			done    = instr_done;
			last_ie = int_exit;
			n++;
			@(posedge mclk);
			#1;
		end
		chk({name, " cycles"}, cyc[11:0], n[11:0]);
		chk({name, " pc"}, pc_exp, pc);
		chk({name, " flags"}, {10'h000, z, c}, {10'h000, flag_z, flag_c});
	endtask

	// Checks the sleeping core stays put, then wakes it.
	task automatic doze(input logic w, input logic s);
		logic [11:0] held;
		held = pc;
		repeat (3)
		begin
			@(negedge mclk);
			chk("wait mode", {11'h000, w}, {11'h000, wait_mode});
			chk("stop mode", {11'h000, s}, {11'h000, stop_mode});
			chk("asleep done", 12'h000, {11'h000, instr_done});
			chk("asleep pc", held, pc);
		end
		wake = 1'b1;
		@(negedge mclk);
		wake = 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_short();
		begin_test(1'b1, 1'b1);
		put(12'h000, 24'h780000, 1);
		put(12'h010, 24'h0C8200, 2);
		put(12'h002, 24'h0E1100, 3);
		put(12'h100, 24'h4D0000, 1);
		put(12'h005, 24'h0C0000, 1);
		put(12'h007, 24'h081600, 2);
		put(12'h00B, 24'h0A0000, 1);
		go();
		step("nonzero far", 2, 12'h010, 1'b0, 1'b0);
		step("zero not", 2, 12'h011, 1'b0, 1'b0);
		step("nocarry back", 2, 12'h002, 1'b0, 1'b0);
		step("carry not", 2, 12'h003, 1'b0, 1'b0);
		step("call", 4, 12'h100, 1'b0, 1'b0);
		step("int exit", 2, 12'h005, 1'b1, 1'b1);
		chk("int exit pulse", 12'h001, {11'h000, last_ie});
		step("zero taken", 2, 12'h007, 1'b1, 1'b1);
		step("nonzero not", 2, 12'h008, 1'b1, 1'b1);
		step("carry taken", 2, 12'h00B, 1'b1, 1'b1);
		step("nocarry not", 2, 12'h00C, 1'b1, 1'b1);
		$display("short branch test done");
	endtask

	task automatic t_bits();
		begin_test(1'b1, 1'b0);
		put(12'h000, 24'h110000, 2);
		put(12'h100, 24'h4D0000, 1);
		put(12'h002, 24'hBB400B, 3);
		put(12'h005, 24'h41EBFF, 3);
		put(12'h008, 24'h1B4300, 2);
		put(12'h00A, 24'hB3407F, 3);
		put(12'h08B, 24'h034180, 3);
		put(12'h00D, 24'hF3FF05, 3);
		put(12'h010, 24'h034305, 3);
		bbc_mem_inst.ds[8'h41] = 8'hFF;
		bbc_mem_inst.ds[8'hFF] = 8'hFF;
		bbc_mem_inst.ds[8'h40] = 8'h00;
		bbc_mem_inst.ds[8'h43] = 8'h00;
		go();
		step("call", 4, 12'h100, 1'b0, 1'b0);
		step("int exit", 2, 12'h002, 1'b1, 1'b0);
		step("set bit5", 4, 12'h004, 1'b1, 1'b0);
		step("clear bit0", 4, 12'h006, 1'b1, 1'b0);
		step("clear bit7", 4, 12'h008, 1'b1, 1'b0);
		step("set bit0", 4, 12'h00A, 1'b1, 1'b0);
		step("if set far", 5, 12'h08B, 1'b1, 1'b1);
		step("if clear back", 5, 12'h00D, 1'b1, 1'b0);
		step("if set not", 5, 12'h010, 1'b1, 1'b0);
		step("if clear not", 5, 12'h013, 1'b1, 1'b1);
		chk("byte 40", 12'h020, {4'h0, bbc_mem_inst.ds[8'h40]});
		chk("byte 41", 12'h0FE, {4'h0, bbc_mem_inst.ds[8'h41]});
		chk("byte FF", 12'h07F, {4'h0, bbc_mem_inst.ds[8'hFF]});
		chk("byte 43", 12'h001, {4'h0, bbc_mem_inst.ds[8'h43]});
		chk("byte 42", 12'h05A, {4'h0, bbc_mem_inst.ds[8'h42]});
		$display("bit test done");
	endtask

	task automatic t_ctl();
		begin_test(1'b0, 1'b1);
		put(12'h000, 24'h1100A9, 3);
		put(12'h003, 24'hBC0000, 1);
		put(12'h100, 24'h4D0000, 1);
		put(12'hABC, 24'h31F000, 2);
		put(12'h3F0, 24'h04CD00, 2);
		put(12'hABE, 24'hED6D6D, 3);
		put(12'hAC1, 24'h040000, 1);
		go();
		step("call", 4, 12'h100, 1'b0, 1'b0);
		step("int exit", 2, 12'h002, 1'b0, 1'b1);
		step("long jump", 4, 12'hABC, 1'b0, 1'b1);
		step("call far", 4, 12'h3F0, 1'b0, 1'b1);
		step("no op", 2, 12'h3F1, 1'b0, 1'b1);
		chk("no op exit pulse", 12'h000, {11'h000, last_ie});
		step("sub exit", 2, 12'hABE, 1'b0, 1'b1);
		step("wait", 2, 12'hABF, 1'b0, 1'b1);
		doze(1'b1, 1'b0);
		step("stop", 2, 12'hAC0, 1'b0, 1'b1);
		doze(1'b0, 1'b1);
		wdog_sel = 1'b1;
		step("stop wdog", 2, 12'hAC1, 1'b0, 1'b1);
		doze(1'b1, 1'b0);
		step("no op after", 2, 12'hAC2, 1'b0, 1'b1);
		$display("control test done");
	endtask

	// An opcode of another group is handed over and finished by that group.
	task automatic t_ext();
		begin_test(1'b0, 1'b0);
		put(12'h000, 24'h170000, 1);
		ext_len     = 2'h1;
		ext_flag_we = 1'b1;
		ext_z       = 1'b1;
		ext_c       = 1'b0;
		ext_done    = 1'b1;
		go();
		@(posedge mclk);
		#1;
		chk("ext req", 12'h001, {11'h000, ext_req});
		chk("ext opcode", 12'h017, {4'h0, ext_opcode});
		chk("ext ind sel", 12'h001, {11'h000, ext_ind_sel});
		step("ext", 1, 12'h001, 1'b1, 1'b0);
		@(negedge mclk);
		ext_done = 1'b0;
		$display("ext handover test done");
	endtask

	// ----------------------------------------
	// Sequence and verdict
	// ----------------------------------------
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			$display("[ERR] run time expected under 3000 seen 3000");
			final_report();
		end
	end

	initial
	begin
		mclk       = 1'b0;
		rst_n      = 1'b0;
		irq_flag_z = 1'b0;
		irq_flag_c = 1'b0;
		wdog_sel   = 1'b0;
		wake       = 1'b0;
		ext_done    = 1'b0;
		ext_len     = 2'h0;
		ext_flag_we = 1'b0;
		ext_z       = 1'b0;
		ext_c       = 1'b0;
		n_mismatch = 0;
		checked    = 0;
		cycles     = 0;
		t_short();
		t_bits();
		t_ctl();
		t_ext();
		final_report();
	end
endmodule
